// File: bench/tmr_pwm_unit_bench.sv
// Self-checking bench for the timer, PWM and tone unit.
// Assumes the unit holds its own assertions; drives Wishbone and pins.
`timescale 1ns/1ps
`default_nettype none
module tmr_pwm_unit_bench;
  logic clk_i = 1'b0; // Bench clock
  logic rst_i = 1'b1; // Sync reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, ext = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack, pwm_oe, pwm, tone_oe, tone;
  logic [7:0] exp_q[$]; // Notes of pending reads
  logic [7:0] v;
  logic [7:0] mode[3] = '{8'h01, 8'h03, 8'h07};
  logic [7:0] after4[3] = '{8'hFE, 8'h01, 8'h00};
  int fails = 0, checks = 0, cycles = 0;

  always #5 clk_i = ~clk_i;

  tmr_pwm_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .inst_tick_i(tick), .ext_count_input_i(ext),
    .port_b_bit_six_oe_o(pwm_oe), .port_b_bit_six_o(pwm),
    .port_b_bit_seven_oe_o(tone_oe), .port_b_bit_seven_o(tone));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Read answers meet the oldest note; we is still held at the ack edge
  always @(posedge clk_i) begin : mon
    logic [7:0] e;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("read data", {24'h0, e}, dat_r);
    end
  end

  // Hang guard, well above the whole run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // One classic cycle; the request stands until ack is seen or the 40-cycle limit runs out
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat_w <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40) fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask : wr

  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, i, 8'h00);
  endtask : rd

  // Separate one-cycle instruction ticks
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i) tick <= 1'b1;
      @(posedge clk_i) tick <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : ticks

  // Slow pulses on the external pin, wide enough for the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i) ext <= 1'b1;
      repeat (5) @(posedge clk_i);
      ext <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask : pulses

  // Steps through eight tone codes, pin against bit i of src
  task automatic tones(input logic [7:0] base, input logic [7:0] src);
    for (int i = 0; i < 8; i++) begin
      wr(4'h5, base + 8'(i));
      repeat (3) @(posedge clk_i);
      chk("tone enable", 32'h1, {31'h0, tone_oe});
      chk("tone level", {31'h0, src[i]}, {31'h0, tone});
    end
  endtask : tones

  // Main sequence
  initial begin
    v = 8'($urandom(32'hCB3D));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h2, 8'h3F);
    rd(4'h5, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h9, 8'h00);
    repeat (4) begin
      v = 8'($urandom());
      wr(4'h0, v);
      rd(4'h0, v);
    end
    $display("reset and load test done");
    // Wrap, reload and one-shot, no prescaler, instruction source
    wr(4'h2, 8'h08);
    for (int m = 0; m < 3; m++) begin
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h02);
      wr(4'h1, mode[m]);
      ticks(4);
      rd(4'h0, after4[m]);
    end
    $display("count mode test done");
    // Prescaler 1:2 then 1:4; rate changed only while disabled
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h10);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h01);
    ticks(4);
    rd(4'h0, 8'h0E);
    rd(4'h4, 8'h04);
    wr(4'h2, 8'h09);
    wr(4'h2, 8'h01);
    ticks(8);
    rd(4'h0, 8'h0C);
    rd(4'h4, 8'h0C);
    tones(8'h80, 8'h0C);
    // External pin, rising then falling edge; ticks ignored
    wr(4'h2, 8'h28);
    pulses(3);
    ticks(2);
    rd(4'h0, 8'h09);
    wr(4'h2, 8'h38);
    pulses(2);
    rd(4'h0, 8'h07);
    $display("prescaler and source test done");
    // PWM reload 4 (five-tick frame), duty 2
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h08);
    wr(4'h3, 8'h02);
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h83);
    repeat (3) @(posedge clk_i);
    chk("pwm enable", 32'h1, {31'h0, pwm_oe});
    chk("pwm level", 32'h0, {31'h0, pwm});
    ticks(2);
    chk("pwm level", 32'h1, {31'h0, pwm});
    wr(4'h1, 8'hC3);
    repeat (3) @(posedge clk_i);
    chk("pwm level", 32'h0, {31'h0, pwm});
    ticks(3);
    chk("pwm level", 32'h1, {31'h0, pwm});
    wr(4'h1, 8'h03);
    repeat (3) @(posedge clk_i);
    chk("pwm enable", 32'h0, {31'h0, pwm_oe});
    $display("pwm test done");
    // Tone from held counter bits, then disabled
    wr(4'h1, 8'h00);
    wr(4'h0, 8'hA5);
    tones(8'h88, 8'hA5);
    wr(4'h5, 8'h08);
    repeat (3) @(posedge clk_i);
    chk("tone enable", 32'h0, {31'h0, tone_oe});
    chk("tone level", 32'h0, {31'h0, tone});
    $display("tone test done");
    // Slowest rate 1:256, changed only while the prescaler is off
    wr(4'h2, 8'h0F);
    wr(4'h2, 8'h07);
    wr(4'h1, 8'h01);
    ticks(243);
    rd(4'h0, 8'hA5);
    rd(4'h4, 8'hFF);
    ticks(1);
    rd(4'h0, 8'hA4);
    $display("slow prescaler test done");
    tally_and_finish();
  end
endmodule : tmr_pwm_unit_bench
`default_nettype wire

// File: design/tmr_pwm_params.svh
// Register offsets, field positions and reset values of the timer unit.
// Assumes a Wishbone slave with 32-bit data and word-aligned registers.
`ifndef TMR_PWM_PARAMS_SVH
`define TMR_PWM_PARAMS_SVH

// Register indices (byte address is four times the index)
`define IDX_COUNTER 4'h0
`define IDX_CTRL_ONE 4'h1
`define IDX_CTRL_TWO 4'h2
`define IDX_DUTY 4'h3
`define IDX_PS_VIEW 4'h4
`define IDX_TONE 4'h5

// Control one fields
`define C1_ENABLE 0
`define C1_RELOAD 1
`define C1_ONESHOT 2
`define C1_PWM_AL 6
`define C1_PWM_EN 7
// Control two fields
`define C2_PS_SEL_LSB 0
`define C2_PS_DIS_N 3
`define C2_EDGE 4
`define C2_SRC 5
// Tone control fields
`define TC_SEL_LSB 0
`define TC_ENABLE 7

// Reset values and counter limits
`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 6'h3F
`define TONE_SEL_RST 4'hF
`define COUNT_UNDERFLOW 8'hFF
`define COUNT_ZERO 8'h00

`endif

// File: design/tmr_pwm_pkg.sv
// Types shared by the timer unit.
// Assumes the params header is included by users of the offsets.
package tmr_pwm_pkg;
  // Run state of the down counter
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } run_state_t;

  // Pin pair toward the port block
  typedef struct packed {
    logic pwm_en;
    logic pwm_lvl;
    logic tone_en;
    logic tone_lvl;
  } pin_out_t;
endpackage : tmr_pwm_pkg

// File: design/tmr_pwm_unit.sv
// Timer with prescaler, single PWM channel and tone output.
// Assumes a classic Wishbone master on clk_i; ext pin is asynchronous.
//
// Local design decision: the Wishbone slave port.
`include "tmr_pwm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tmr_pwm_unit
  import tmr_pwm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic inst_tick_i,
  input wire logic ext_count_input_i,
  output logic port_b_bit_six_oe_o,
  output logic port_b_bit_six_o,
  output logic port_b_bit_seven_oe_o,
  output logic port_b_bit_seven_o
);

  // Bus decode
  logic [3:0] idx;
  logic req;
  logic wr_b0;
  assign idx = wb_adr_i[5:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_b0 = req & wb_we_i & wb_sel_i[0];

  // Software state
  logic [7:0] ctrl1_r, ctrl1_nxt;
  logic [5:0] ctrl2_r, ctrl2_nxt;
  logic [7:0] duty_r, duty_nxt;
  logic [7:0] reload_r, reload_nxt;
  logic tone_en_r, tone_en_nxt;
  logic [3:0] tone_sel_r, tone_sel_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;

  // Counting state
  logic [7:0] count_r, count_nxt;
  logic [7:0] ps_r, ps_nxt;
  logic pwm_act_r, pwm_act_nxt;
  run_state_t st_r, st_nxt;
  logic pwm_q_r, tone_q_r;

  // Pin synchroniser; first stage read only by second
  logic ext_s1_r, ext_s2_r, ext_s3_r;

  // Count tick sourcing
  logic src_tick;
  logic ps_tick;
  logic cnt_tick;
  logic ext_rise, ext_fall;
  logic [2:0] ps_sel;
  assign ps_sel = ctrl2_r[`C2_PS_SEL_LSB +: 3];
  assign ext_rise = ext_s2_r & ~ext_s3_r;
  assign ext_fall = ~ext_s2_r & ext_s3_r;

  // Source and edge choice
  always_comb begin
    if (ctrl2_r[`C2_SRC]) begin
      src_tick = ctrl2_r[`C2_EDGE] ? ext_fall : ext_rise;
    end else begin
      src_tick = inst_tick_i;
    end
  end

  // Prescaler terminal: low code+1 bits all ones on a source tick
  logic [7:0] ps_mask;
  // divide by two to code plus one
  assign ps_mask = 8'hFF >> (3'h7 - ps_sel);
  assign ps_tick = src_tick & ((ps_r & ps_mask) == ps_mask);
  // Disabled prescaler passes source straight through
  assign cnt_tick = ctrl2_r[`C2_PS_DIS_N] ? src_tick : ps_tick;

  // Register writes and reads
  always_comb begin
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    duty_nxt = duty_r;
    reload_nxt = reload_r;
    tone_en_nxt = tone_en_r;
    tone_sel_nxt = tone_sel_r;
    ack_nxt = req;
    rdat_nxt = 32'h0000_0000;
    if (wr_b0) begin
      case (idx)
        `IDX_COUNTER: reload_nxt = wb_dat_i[7:0];
        `IDX_CTRL_ONE: ctrl1_nxt = wb_dat_i[7:0] & 8'hC7;
        // rate field is software's duty to change safely
        `IDX_CTRL_TWO: ctrl2_nxt = wb_dat_i[5:0];
        `IDX_DUTY: duty_nxt = wb_dat_i[7:0];
        `IDX_TONE: begin
          tone_en_nxt = wb_dat_i[`TC_ENABLE];
          tone_sel_nxt = wb_dat_i[`TC_SEL_LSB +: 4];
        end
        default: ;
      endcase
    end
    if (req & ~wb_we_i) begin
      case (idx)
        `IDX_COUNTER: rdat_nxt = {24'h00_0000, count_r};
        `IDX_CTRL_ONE: rdat_nxt = {24'h00_0000, 2'b00, 3'b000,
                                   ctrl1_r[2:0]};
        `IDX_CTRL_TWO: rdat_nxt = {26'h000_0000, ctrl2_r};
        `IDX_PS_VIEW: rdat_nxt = {24'h00_0000, ps_r};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Counter, prescaler and PWM state
  logic cnt_wr;
  assign cnt_wr = wr_b0 & (idx == `IDX_COUNTER);
  always_comb begin
    count_nxt = count_r;
    ps_nxt = ps_r;
    pwm_act_nxt = pwm_act_r;
    st_nxt = st_r;
    // Prescaler counts source ticks when enabled, only while st_r is ST_RUN
    if (!ctrl2_r[`C2_PS_DIS_N] && src_tick && st_r == ST_RUN) begin
      ps_nxt = ps_r + 8'h01;
    end
    case (st_r)
      ST_IDLE: begin
        pwm_act_nxt = 1'b0;
        if (ctrl1_r[`C1_ENABLE]) st_nxt = ST_RUN;
      end
      ST_RUN: begin
        // active from duty match onward; underflow below wins
        if (count_r == duty_r) pwm_act_nxt = 1'b1;
        if (!ctrl1_r[`C1_ENABLE]) begin
          st_nxt = ST_IDLE;
        end else if (cnt_tick) begin
          if (count_r == `COUNT_ZERO) begin
            pwm_act_nxt = 1'b0;
            if (ctrl1_r[`C1_ONESHOT]) begin
              st_nxt = ST_DONE;
            end else if (ctrl1_r[`C1_RELOAD]) begin
              count_nxt = reload_r;
            end else begin
              count_nxt = `COUNT_UNDERFLOW;
            end
          end else begin
            count_nxt = count_r - 8'h01;
          end
        end
      end
      ST_DONE: begin
        if (!ctrl1_r[`C1_ENABLE]) st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Software write overrides count and restarts one-shot
    if (cnt_wr) begin
      count_nxt = wb_dat_i[7:0];
      if (st_r == ST_DONE) st_nxt = ST_RUN;
    end
    if (!ctrl1_r[`C1_ENABLE]) pwm_act_nxt = 1'b0;
  end

  // Tone waveform choice
  logic tone_wave;
  always_comb begin
    if (tone_sel_r[3]) tone_wave = count_r[tone_sel_r[2:0]];
    else tone_wave = ps_r[tone_sel_r[2:0]];
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_r <= `CTRL_ONE_RST;
      ctrl2_r <= `CTRL_TWO_RST;
      duty_r <= 8'h00;
      reload_r <= 8'h00;
      tone_en_r <= 1'b0;
      tone_sel_r <= `TONE_SEL_RST;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      count_r <= 8'h00;
      ps_r <= 8'h00;
      pwm_act_r <= 1'b0;
      st_r <= ST_IDLE;
      pwm_q_r <= 1'b0;
      tone_q_r <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      duty_r <= duty_nxt;
      reload_r <= reload_nxt;
      tone_en_r <= tone_en_nxt;
      tone_sel_r <= tone_sel_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      count_r <= count_nxt;
      ps_r <= ps_nxt;
      pwm_act_r <= pwm_act_nxt;
      st_r <= st_nxt;
      pwm_q_r <= pwm_act_nxt ^ ctrl1_nxt[`C1_PWM_AL];
      tone_q_r <= tone_en_nxt & tone_wave;
      ext_s1_r <= ext_count_input_i;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Outputs
  pin_out_t pins;
  always_comb begin
    pins.pwm_en = ctrl1_r[`C1_PWM_EN];
    pins.pwm_lvl = pwm_q_r;
    pins.tone_en = tone_en_r;
    pins.tone_lvl = tone_q_r;
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign port_b_bit_six_oe_o = pins.pwm_en;
  assign port_b_bit_six_o = pins.pwm_lvl;
  assign port_b_bit_seven_oe_o = pins.tone_en;
  assign port_b_bit_seven_o = pins.tone_lvl;

  // Checks
  wrap_ff_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == ST_RUN && ctrl1_r[2:0] == 3'b001 && cnt_tick && !cnt_wr &&
    count_r == 8'h00 |=> count_r == 8'hFF)
    else $error("no wrap to FF");
  reload_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == ST_RUN && ctrl1_r[2:0] == 3'b011 && cnt_tick && !cnt_wr &&
    count_r == 8'h00 |=> count_r == $past(reload_r))
    else $error("no reload");
  oneshot_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == ST_DONE && !cnt_wr && ctrl1_r[0] |=> $stable(count_r))
    else $error("one-shot kept counting");
  pwm_pol_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == ST_IDLE |-> port_b_bit_six_o == ctrl1_r[`C1_PWM_AL])
    else $error("pwm polarity");
  cnt_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_wr |=> count_r == $past(wb_dat_i[7:0]) &&
    reload_r == $past(wb_dat_i[7:0]))
    else $error("counter write lost");
  duty_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == ST_RUN && ctrl1_r[0] && count_r == duty_r &&
    !(cnt_tick && count_r == 8'h00) |=> pwm_act_r)
    else $error("duty match missed");
  tone_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tone_en_r && !tone_en_nxt |=> !port_b_bit_seven_o)
    else $error("tone not held low");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  cv_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r == ST_RUN && cnt_tick && count_r == 8'h00);
  cv_done: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r == ST_DONE);
  cv_pwm: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(pwm_act_r));

endmodule : tmr_pwm_unit
`default_nettype wire
